// file: design/gie_cfg.svh
// register offsets, reset values and widths of the gpio input/event block
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef GIE_CFG_SVH
`define GIE_CFG_SVH

// ==========================================================
// widths
`define GIE_PINS 8
`define GIE_AW 8
`define GIE_DW 32

// ==========================================================
// byte offsets
`define GIE_OFF_PIN_LEVEL 8'h00
`define GIE_OFF_NOTIFY_EN 8'h04
`define GIE_OFF_EDGE_STAT 8'h08
`define GIE_OFF_STAT_CLR 8'h0c
`define GIE_OFF_POLARITY 8'h10
`define GIE_OFF_EVT_TYPE 8'h14
`define GIE_OFF_ROUTE_IRQ 8'h18
`define GIE_OFF_ROUTE_SMI 8'h1c
`define GIE_OFF_ROUTE_WAKE 8'h20

// ==========================================================
// reset values
`define GIE_RST_NOTIFY_EN 8'h00
`define GIE_RST_EDGE_STAT 8'h00
`define GIE_RST_POLARITY 8'h00
`define GIE_RST_EVT_TYPE 8'h00
`define GIE_RST_ROUTE_IRQ 8'hff
`define GIE_RST_ROUTE_SMI 8'h00
`define GIE_RST_ROUTE_WAKE 8'h00

`endif

// file: design/gie_pkg.sv
// types of the gpio input/event block
// assumes gie_cfg.svh is on the include path
`include "gie_cfg.svh"

package gie_pkg;

    // ==========================================================
    // register selector
    typedef enum logic [3:0] {
        GIE_REG_NONE,
        GIE_REG_PIN_LEVEL,
        GIE_REG_NOTIFY_EN,
        GIE_REG_EDGE_STAT,
        GIE_REG_STAT_CLR,
        GIE_REG_POLARITY,
        GIE_REG_EVT_TYPE,
        GIE_REG_ROUTE_IRQ,
        GIE_REG_ROUTE_SMI,
        GIE_REG_ROUTE_WAKE
    } gie_reg_e;

    typedef logic [`GIE_PINS-1:0] gie_pins_t;

    // ==========================================================
    // wishbone request as one bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [`GIE_AW-1:0] adr;
        logic [3:0] sel;
        logic [`GIE_DW-1:0] dat;
    } gie_wb_req_s;

    // ==========================================================
    // whole state of the block
    typedef struct packed {
        gie_pins_t sync1;
        gie_pins_t sync2;
        gie_pins_t prev;
        gie_pins_t notify_en;
        gie_pins_t edge_stat;
        gie_pins_t polarity;
        gie_pins_t evt_type;
        gie_pins_t route_irq;
        gie_pins_t route_smi;
        gie_pins_t route_wake;
        gie_pins_t notify;
        logic irq;
        logic smi;
        logic wake;
        logic ack;
        logic [`GIE_DW-1:0] rdat;
    } gie_state_s;

endpackage : gie_pkg

// file: design/gie_port.sv
// gpio input level and edge event logic with a classic wishbone slave
// assumes pins are asynchronous to clock_i; bus master is classic single cycle
`timescale 1ns/1ns
`include "gie_cfg.svh"

// What this block does
// - input register bit n reads the current level of pin n, bits 7..0
// - input read shows pin levels whatever the configuration or output data
// - writes to the input register are dropped with no effect
// - enable bit 1 lets a pin notify, 0 masks it; all reset to 0
// - enable bit never changes status capture
// - status bit set by an active edge, sticky until cleared, resets to 0
// - only the edge matching the pin polarity setting is active
// - capture ignores event type and enable bit
// - writing 1 clears a status bit, writing 0 leaves it
// - per-pin routing to irq, smi and wake; only irq routing on after reset
module gie_port
    import gie_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`GIE_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`GIE_DW-1:0] wb_dat_i,
    output logic [`GIE_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic [`GIE_PINS-1:0] pin_i,
    // notification and routing
    output logic [`GIE_PINS-1:0] notify_o,
    output logic irq_o,
    output logic smi_o,
    output logic wake_request_out_o
);

    // ==========================================================
    // address decode
    function automatic gie_reg_e reg_decode(input logic [`GIE_AW-1:0] adr);
        gie_reg_e r;
        r = GIE_REG_NONE;
        if (adr == `GIE_OFF_PIN_LEVEL) begin
            r = GIE_REG_PIN_LEVEL;
        end else if (adr == `GIE_OFF_NOTIFY_EN) begin
            r = GIE_REG_NOTIFY_EN;
        end else if (adr == `GIE_OFF_EDGE_STAT) begin
            r = GIE_REG_EDGE_STAT;
        end else if (adr == `GIE_OFF_STAT_CLR) begin
            r = GIE_REG_STAT_CLR;
        end else if (adr == `GIE_OFF_POLARITY) begin
            r = GIE_REG_POLARITY;
        end else if (adr == `GIE_OFF_EVT_TYPE) begin
            r = GIE_REG_EVT_TYPE;
        end else if (adr == `GIE_OFF_ROUTE_IRQ) begin
            r = GIE_REG_ROUTE_IRQ;
        end else if (adr == `GIE_OFF_ROUTE_SMI) begin
            r = GIE_REG_ROUTE_SMI;
        end else if (adr == `GIE_OFF_ROUTE_WAKE) begin
            r = GIE_REG_ROUTE_WAKE;
        end
        return r;
    endfunction : reg_decode

    // ==========================================================
    // state
    localparam gie_state_s RESET_STATE = '{
        sync1: '0,
        sync2: '0,
        prev: '0,
        notify_en: `GIE_RST_NOTIFY_EN,
        edge_stat: `GIE_RST_EDGE_STAT,
        polarity: `GIE_RST_POLARITY,
        evt_type: `GIE_RST_EVT_TYPE,
        route_irq: `GIE_RST_ROUTE_IRQ,
        route_smi: `GIE_RST_ROUTE_SMI,
        route_wake: `GIE_RST_ROUTE_WAKE,
        notify: '0,
        irq: 1'b0,
        smi: 1'b0,
        wake: 1'b0,
        ack: 1'b0,
        rdat: '0
    };

    gie_state_s st_q;
    gie_state_s st_d;
    gie_wb_req_s req;
    gie_reg_e sel_reg;
    logic wr_take;
    logic lane0;
    gie_pins_t edge_hit;
    gie_pins_t clr_mask;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign sel_reg = reg_decode(req.adr);
    // write lands on the edge where the master sees ack
    assign wr_take = req.cyc & req.stb & req.we & st_q.ack;
    assign lane0 = req.sel[0];

    // ==========================================================
    // edge detection on synchronised levels; event type and enable play no part
    assign edge_hit = (st_q.polarity & st_q.sync2 & ~st_q.prev)
                    | (~st_q.polarity & ~st_q.sync2 & st_q.prev);

    assign clr_mask = (wr_take && lane0 && (sel_reg == GIE_REG_EDGE_STAT || sel_reg == GIE_REG_STAT_CLR))
                    ? req.dat[`GIE_PINS-1:0] : '0;

    always_comb begin
        st_d = st_q;
        // only sync1 feeds sync2; nothing else looks at the first stage
        st_d.sync1 = pin_i;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;

        // a new edge beats a clear in the same cycle
        st_d.edge_stat = (st_q.edge_stat & ~clr_mask) | edge_hit;

        if (wr_take && lane0) begin
            if (sel_reg == GIE_REG_NOTIFY_EN) begin
                st_d.notify_en = req.dat[`GIE_PINS-1:0];
            end else if (sel_reg == GIE_REG_POLARITY) begin
                st_d.polarity = req.dat[`GIE_PINS-1:0];
            end else if (sel_reg == GIE_REG_EVT_TYPE) begin
                st_d.evt_type = req.dat[`GIE_PINS-1:0];
            end else if (sel_reg == GIE_REG_ROUTE_IRQ) begin
                st_d.route_irq = req.dat[`GIE_PINS-1:0];
            end else if (sel_reg == GIE_REG_ROUTE_SMI) begin
                st_d.route_smi = req.dat[`GIE_PINS-1:0];
            end else if (sel_reg == GIE_REG_ROUTE_WAKE) begin
                st_d.route_wake = req.dat[`GIE_PINS-1:0];
            end
            // pin level register is not a target: write dropped
        end

        // outputs computed from next values so they track the flags exactly
        st_d.notify = st_d.edge_stat & st_d.notify_en;
        st_d.irq = |(st_d.notify & st_d.route_irq);
        st_d.smi = |(st_d.notify & st_d.route_smi);
        st_d.wake = |(st_d.notify & st_d.route_wake);

        // one-cycle ack, one wait state; unmapped offsets ack with zero data
        st_d.ack = req.cyc & req.stb & ~st_q.ack;
        st_d.rdat = '0;
        if (req.cyc && req.stb && !st_q.ack && !req.we) begin
            if (sel_reg == GIE_REG_PIN_LEVEL) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.sync2;
            end else if (sel_reg == GIE_REG_NOTIFY_EN) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.notify_en;
            end else if (sel_reg == GIE_REG_EDGE_STAT) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.edge_stat;
            end else if (sel_reg == GIE_REG_POLARITY) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.polarity;
            end else if (sel_reg == GIE_REG_EVT_TYPE) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.evt_type;
            end else if (sel_reg == GIE_REG_ROUTE_IRQ) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.route_irq;
            end else if (sel_reg == GIE_REG_ROUTE_SMI) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.route_smi;
            end else if (sel_reg == GIE_REG_ROUTE_WAKE) begin
                st_d.rdat[`GIE_PINS-1:0] = st_q.route_wake;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= RESET_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_dat_o = st_q.rdat;
    assign wb_ack_o = st_q.ack;
    assign notify_o = st_q.notify;
    assign irq_o = st_q.irq;
    assign smi_o = st_q.smi;
    assign wake_request_out_o = st_q.wake;

    // ==========================================================
    // checks
    a_ack_one_cycle: assert property (@(posedge clock_i) disable iff (!resetn_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_latency: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack not given one cycle after request");

    a_pin_read_level: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `GIE_OFF_PIN_LEVEL)
        |=> (wb_dat_o == {24'h000000, $past(st_q.sync2)}))
        else $error("pin level read does not match synchronised pins");

    a_edge_sets_stat: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (|edge_hit) |=> ((st_q.edge_stat & $past(edge_hit)) == $past(edge_hit)))
        else $error("active edge did not set its status bit");

    a_no_edge_no_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
        1'b1 |=> ((st_q.edge_stat & ~$past(st_q.edge_stat) & ~$past(edge_hit)) == 8'h00))
        else $error("status bit set without an active edge");

    a_w1c_clears: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (|clr_mask) |=> ((st_q.edge_stat & $past(clr_mask) & ~$past(edge_hit)) == 8'h00))
        else $error("write one did not clear status");

    a_w0_keeps: assert property (@(posedge clock_i) disable iff (!resetn_i)
        1'b1 |=> ((~st_q.edge_stat & $past(st_q.edge_stat) & ~$past(clr_mask)) == 8'h00))
        else $error("status bit lost without a clear");

    a_notify_gated: assert property (@(posedge clock_i) disable iff (!resetn_i)
        notify_o == (st_q.edge_stat & st_q.notify_en))
        else $error("notify differs from status and enable");

    a_irq_route: assert property (@(posedge clock_i) disable iff (!resetn_i)
        irq_o == (|(notify_o & st_q.route_irq)))
        else $error("irq line differs from routed notifications");

    a_smi_route: assert property (@(posedge clock_i) disable iff (!resetn_i)
        smi_o == (|(notify_o & st_q.route_smi)))
        else $error("smi line differs from routed notifications");

    a_wake_route: assert property (@(posedge clock_i) disable iff (!resetn_i)
        wake_request_out_o == (|(notify_o & st_q.route_wake)))
        else $error("wake request differs from routed notifications");

    a_irq_needs_enable: assert property (@(posedge clock_i) disable iff (!resetn_i)
        irq_o |-> (|(st_q.edge_stat & st_q.notify_en)))
        else $error("irq raised with no enabled status bit");

    // ==========================================================
    // bus timing and read data
    a_ack_from_request: assert property (@(posedge clock_i) disable iff (!resetn_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack given without a taken request");

    a_rdat_idle_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !wb_ack_o |-> (wb_dat_o == 32'h00000000))
        else $error("read data not zero outside the ack cycle");

    a_rdat_upper_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
        wb_dat_o[`GIE_DW-1:`GIE_PINS] == 24'h000000)
        else $error("read data upper bits not zero");

    a_clr_reads_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `GIE_OFF_STAT_CLR)
        |=> (wb_dat_o == 32'h00000000))
        else $error("clear register read not zero");

    a_enable_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `GIE_OFF_NOTIFY_EN)
        |=> (wb_dat_o == {24'h000000, $past(st_q.notify_en)}))
        else $error("enable read does not match register");

    a_stat_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `GIE_OFF_EDGE_STAT)
        |=> (wb_dat_o == {24'h000000, $past(st_q.edge_stat)}))
        else $error("status read does not match register");

    // ==========================================================
    // register writes; a write lands on the edge where ack is high
    a_pin_write_dropped: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `GIE_OFF_PIN_LEVEL)
        |=> (st_q.notify_en == $past(st_q.notify_en) && st_q.polarity == $past(st_q.polarity)
            && st_q.evt_type == $past(st_q.evt_type) && st_q.route_irq == $past(st_q.route_irq)))
        else $error("write to the pin level register changed state");

    a_enable_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == `GIE_OFF_NOTIFY_EN)
        |=> (st_q.notify_en == $past(wb_dat_i[`GIE_PINS-1:0])))
        else $error("enable write did not land");

    a_enable_keeps: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `GIE_OFF_NOTIFY_EN)
        |=> $stable(st_q.notify_en))
        else $error("enable changed without a write");

    a_polarity_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == `GIE_OFF_POLARITY)
        |=> (st_q.polarity == $past(wb_dat_i[`GIE_PINS-1:0])))
        else $error("polarity write did not land");

    a_polarity_keeps: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `GIE_OFF_POLARITY)
        |=> $stable(st_q.polarity))
        else $error("polarity changed without a write");

    a_evt_type_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == `GIE_OFF_EVT_TYPE)
        |=> (st_q.evt_type == $past(wb_dat_i[`GIE_PINS-1:0])))
        else $error("event type write did not land");

    a_evt_type_keeps: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `GIE_OFF_EVT_TYPE)
        |=> $stable(st_q.evt_type))
        else $error("event type changed without a write");

    a_route_irq_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == `GIE_OFF_ROUTE_IRQ)
        |=> (st_q.route_irq == $past(wb_dat_i[`GIE_PINS-1:0])))
        else $error("irq routing write did not land");

    a_route_smi_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == `GIE_OFF_ROUTE_SMI)
        |=> (st_q.route_smi == $past(wb_dat_i[`GIE_PINS-1:0])))
        else $error("smi routing write did not land");

    a_route_wake_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == `GIE_OFF_ROUTE_WAKE)
        |=> (st_q.route_wake == $past(wb_dat_i[`GIE_PINS-1:0])))
        else $error("wake routing write did not land");

    // ==========================================================
    // pin path; the level check runs only once both sync stages have run out of reset
    a_level_follows_pin: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ($past(resetn_i) && $past(resetn_i, 2)) |-> (st_q.sync2 == $past(pin_i, 2)))
        else $error("synchronised level does not follow the pins");

    a_prev_follows: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $past(resetn_i) |-> (st_q.prev == $past(st_q.sync2)))
        else $error("edge stage does not follow the synchronised level");

    a_stat_next: assert property (@(posedge clock_i) disable iff (!resetn_i)
        1'b1 |=> (st_q.edge_stat == (($past(st_q.edge_stat) & ~$past(clr_mask)) | $past(edge_hit))))
        else $error("status moved other than by an edge or a clear");

    // ==========================================================
    // per pin: an edge of the wrong direction never sets status; an active edge always sets it
    for (genvar gi = 0; gi < `GIE_PINS; gi++) begin : g_pin_chk
        a_rise_ignored: assert property (@(posedge clock_i) disable iff (!resetn_i)
            (!st_q.polarity[gi] && st_q.sync2[gi] && !st_q.prev[gi] && !st_q.edge_stat[gi])
            |=> !st_q.edge_stat[gi])
            else $error("rising edge set status of a falling edge pin");

        a_fall_ignored: assert property (@(posedge clock_i) disable iff (!resetn_i)
            (st_q.polarity[gi] && !st_q.sync2[gi] && st_q.prev[gi] && !st_q.edge_stat[gi])
            |=> !st_q.edge_stat[gi])
            else $error("falling edge set status of a rising edge pin");

        a_active_sets: assert property (@(posedge clock_i) disable iff (!resetn_i)
            (st_q.polarity[gi] ? (st_q.sync2[gi] && !st_q.prev[gi]) : (!st_q.sync2[gi] && st_q.prev[gi]))
            |=> st_q.edge_stat[gi])
            else $error("active edge of a pin did not set its status bit");
    end

endmodule : gie_port

// file: verification/gie_pin_model.sv
// far side of the gpio input block: eight externally driven pins
// assumes the bench commands the wanted levels; pins change after a clock edge
`timescale 1ns/1ns

// ==========================================================
// pin driver
module gie_pin_model (
    // clock
    input wire logic clock_i,
    // commanded levels
    input wire logic [7:0] level_i,
    // pins
    output logic [7:0] pin_o
);
    // driven continuously, never released: pins are plain inputs of the block
    always_ff @(posedge clock_i) begin
        pin_o <= level_i;
    end
endmodule : gie_pin_model

// file: verification/tb_top.sv
// self-checking bench of the gpio input and edge event block
// assumes gie_cfg.svh on the include path and the pin model compiled first
`timescale 1ns/1ns

// ==========================================================
// bench
module tb_top;
    import gie_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} gie_row_s;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, lvl = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, q;
    wire [7:0] pins, notify;
    wire [31:0] dat_o;
    wire ack, irq, smi, wake;
    int n_errors = 0, checks = 0, tick = 0;
    // offset, data: write value or expected read
    gie_row_s rows[16] = '{
        '{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h08, 32'h0}, '{1'b0, 8'h10, 32'h0},
        '{1'b0, 8'h14, 32'h0}, '{1'b0, 8'h18, 32'hff}, '{1'b0, 8'h1c, 32'h0},
        '{1'b0, 8'h20, 32'h0}, '{1'b0, 8'h0c, 32'h0}, '{1'b0, 8'h24, 32'h0},
        '{1'b1, 8'h04, 32'h0f}, '{1'b0, 8'h04, 32'h0f}, '{1'b1, 8'h00, 32'hff},
        '{1'b0, 8'h00, 32'h0}, '{1'b1, 8'h14, 32'h3c}, '{1'b0, 8'h14, 32'h3c},
        '{1'b1, 8'h24, 32'hff}};

    always #5 clock_i = ~clock_i;

    gie_pin_model u_pins (.clock_i(clock_i), .level_i(lvl), .pin_o(pins));
    gie_port DUT (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .pin_i(pins), .notify_o(notify), .irq_o(irq), .smi_o(smi),
        .wake_request_out_o(wake));

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // classic single cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do @(posedge clock_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock_i);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic pins_to(input logic [7:0] v);
        lvl <= v;
        // model flop plus two sync stages plus edge stage
        repeat (5) @(posedge clock_i);
    endtask : pins_to

    task automatic stop_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // hang guard, about thirty times the expected run
    always @(posedge clock_i) begin
        tick <= tick + 1;
        if (tick == 4000) begin
            n_errors++;
            stop_test();
        end
    end

    // ==========================================================
    // sequence
    initial begin
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
            else rd(rows[i].a, rows[i].d);
        end
        pins_to(8'h5a);
        rd(8'h00, 32'h5a);
        rd(8'h08, 32'h0);
        wb(1'b1, 8'h10, 32'hff);
        pins_to(8'hff);
        pins_to(8'h00);
        rd(8'h08, 32'ha5);
        chk({24'h0, notify}, 32'h05);
        chk({29'h0, irq, smi, wake}, 32'h4);
        wb(1'b1, 8'h08, 32'h01);
        rd(8'h08, 32'ha4);
        wb(1'b1, 8'h0c, 32'h04);
        wb(1'b1, 8'h08, 32'h00);
        rd(8'h08, 32'ha0);
        chk({31'h0, irq}, 32'h0);
        // software only trusts status of enabled pins from here on
        wb(1'b1, 8'h1c, 32'hff);
        wb(1'b1, 8'h04, 32'hff);
        rd(8'h04, 32'hff);
        chk({24'h0, notify}, 32'ha0);
        chk({29'h0, irq, smi, wake}, 32'h6);
        wb(1'b1, 8'h20, 32'h80);
        chk({29'h0, irq, smi, wake}, 32'h7);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk({29'h0, irq, smi, wake}, 32'h0);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        stop_test();
    end
endmodule : tb_top
